// >>> logic/modem_opt_params.svh
// Offsets, field positions, reset values and codes of the modem option registers
`ifndef MODEM_OPT_PARAMS_SVH
`define MODEM_OPT_PARAMS_SVH
`define OFS_NEG_ACTION 3'h0
`define OFS_SOFT_SWITCH 3'h1
`define OFS_BREAK 3'h2
`define OFS_FAIL_REASON 3'h3
`define OFS_EXT_RESULT 3'h4
`define RST_NEG_ACTION 8'h07
`define RST_SOFT_SWITCH 8'h00
`define RST_BREAK 8'h80
`define RST_FAIL_REASON 8'h00
`define RST_EXT_RESULT 8'h00
`define NEG_LAPM 8'h00
`define NEG_ENABLE 8'h07
`define NEG_FALLBACK 8'h80
`define BRK_EXPEDITED 8'h03
`define BRK_DESTRUCTIVE 8'h07
`define BRK_IN_SEQUENCE 8'h80
`define FAIL_NORMAL 8'h00
`define FAIL_CARRIER 8'h04
`define FAIL_NO_EC 8'h05
`define FAIL_NO_PROTO 8'h09
`define FAIL_REMOTE 8'h0c
`define FAIL_NO_RESP 8'h0d
`define FAIL_VIOLATION 8'h0e
`define RETX_LIMIT 4'ha
`define SW_CMD_SET 0
`define SW_REMOTE_CFG 1
`define SW_CALLBACK 2
`define SW_ANSWER 3
`define XR_LINE_SPEED 0
`define XR_EC_TAG 1
`define XR_CARRIER 2
`define XR_PROTOCOL 3
`define XR_COMPRESSION 5
`endif

// >>> logic/modem_opt_pkg.sv
// Types of the modem option register block
package modem_opt_pkg;
  typedef enum logic [1:0] {neg_detect, neg_lapm, neg_fallback} neg_mode_t;
  typedef enum logic [1:0] {brk_in_sequence, brk_expedited, brk_destructive} brk_mode_t;
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;
  typedef struct packed {
    logic carrier_loss;
    logic no_ec_modem;
    logic no_common_proto;
    logic remote_disc;
    logic retransmit;
    logic violation;
    logic normal_disc;
  } fail_evt_t;
  typedef struct packed {
    logic line_speed;
    logic ec_tag;
    logic carrier;
    logic protocol;
    logic compression;
  } result_en_t;
  typedef struct packed {
    logic [7:0] neg_action_r;
    logic [7:0] soft_switch_r;
    logic [7:0] break_r;
    logic [7:0] fail_reason_r;
    logic [7:0] ext_result_r;
    logic [7:0] rdata_r;
    logic [3:0] retx_cnt_r;
    logic recorded_r;
  } opt_state_t;
endpackage

// >>> logic/modem_option_register_decode.sv
// Modem option registers with decoded mode outputs and failure cause capture
`timescale 1ns/100ps
`include "modem_opt_params.svh"
module modem_option_register_decode #(
  parameter int REG_W = 8,
  parameter int CNT_W = 4,
  parameter int RETX_MAX = `RETX_LIMIT
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire modem_opt_pkg::reg_req_t req,
  output logic [7:0] rdata,
  // Link events from the modem core
  input wire modem_opt_pkg::fail_evt_t fail_evt,
  input wire logic retx_event,
  input wire logic ack_event,
  input wire logic no_carrier,
  input wire logic call_start,
  // Decoded modes
  output modem_opt_pkg::neg_mode_t neg_mode,
  output modem_opt_pkg::brk_mode_t brk_mode,
  output logic break_immediate,
  output logic break_discard,
  output logic command_set_select,
  output logic remote_config_permit,
  output logic callback_security_enable,
  output logic answer_select,
  output modem_opt_pkg::result_en_t result_force,
  output logic fail_valid
);
  import modem_opt_pkg::*;

  // Parameter limits
  if (REG_W != 8) begin : g_bad_width
    $error("Register width must be 8");
  end
  if (CNT_W != 4) begin : g_bad_count
    $error("Retransmission counter must be 4 bits");
  end
  if (RETX_MAX < 1 || RETX_MAX > 15) begin : g_bad_limit
    $error("Retransmission limit out of range");
  end

  // State and next state
  opt_state_t s_r;
  opt_state_t s_nxt;

  // Write and read selects
  logic wr_neg;
  logic wr_soft;
  logic wr_brk;
  logic wr_ext;
  logic rd_neg;
  logic rd_soft;
  logic rd_brk;
  logic rd_fail;
  logic rd_ext;
  logic [7:0] rd_word;

  // Cause capture
  logic [7:0] cause;
  logic cause_hit;
  logic retx_spent;
  logic cnt_clear;
  logic cnt_step;
  logic cause_take;
  logic silent_take;

  // Register selects
  always_comb begin
    wr_neg = 1'b0;
    wr_soft = 1'b0;
    wr_brk = 1'b0;
    wr_ext = 1'b0;
    rd_neg = 1'b0;
    rd_soft = 1'b0;
    rd_brk = 1'b0;
    rd_fail = 1'b0;
    rd_ext = 1'b0;
    if (req.wr) begin
      case (req.addr)
        `OFS_NEG_ACTION: begin
          wr_neg = 1'b1;
        end
        `OFS_SOFT_SWITCH: begin
          wr_soft = 1'b1;
        end
        `OFS_BREAK: begin
          wr_brk = 1'b1;
        end
        `OFS_EXT_RESULT: begin
          wr_ext = 1'b1;
        end
        default: begin
          wr_neg = 1'b0;
        end
      endcase
    end
    if (req.rd) begin
      case (req.addr)
        `OFS_NEG_ACTION: begin
          rd_neg = 1'b1;
        end
        `OFS_SOFT_SWITCH: begin
          rd_soft = 1'b1;
        end
        `OFS_BREAK: begin
          rd_brk = 1'b1;
        end
        `OFS_FAIL_REASON: begin
          rd_fail = 1'b1;
        end
        `OFS_EXT_RESULT: begin
          rd_ext = 1'b1;
        end
        default: begin
          rd_neg = 1'b0;
        end
      endcase
    end
  end

  // Read data mux
  always_comb begin
    rd_word = 8'h00;
    if (rd_neg) begin
      rd_word = s_r.neg_action_r;
    end
    if (rd_soft) begin
      rd_word = s_r.soft_switch_r;
    end
    if (rd_brk) begin
      rd_word = s_r.break_r;
    end
    if (rd_fail) begin
      rd_word = s_r.fail_reason_r;
    end
    if (rd_ext) begin
      rd_word = s_r.ext_result_r;
    end
  end

  // limit reached, stale count ignored on rearm
  assign retx_spent = (s_r.retx_cnt_r >= 4'(RETX_MAX)) && !call_start;

  always_comb begin
    cause = `FAIL_NORMAL;
    cause_hit = 1'b1;
    if (retx_spent) begin
      cause = `FAIL_NO_RESP;
    end else if (fail_evt.carrier_loss) begin
      cause = `FAIL_CARRIER;
    end else if (fail_evt.no_ec_modem) begin
      cause = `FAIL_NO_EC;
    end else if (fail_evt.no_common_proto) begin
      cause = `FAIL_NO_PROTO;
    end else if (fail_evt.retransmit) begin
      cause = `FAIL_NO_RESP;
    end else if (fail_evt.violation) begin
      cause = `FAIL_VIOLATION;
    end else if (fail_evt.remote_disc) begin
      cause = `FAIL_REMOTE;
    end else if (fail_evt.normal_disc) begin
      cause = `FAIL_NORMAL;
    end else begin
      cause_hit = 1'b0;
    end
  end

  assign cnt_clear = call_start || ack_event;
  assign cnt_step = retx_event && (s_r.retx_cnt_r < 4'(RETX_MAX));

  assign cause_take = cause_hit && (call_start || !s_r.recorded_r);
  assign silent_take = !cause_hit && no_carrier && (call_start || !s_r.recorded_r);

  // Next state
  always_comb begin
    s_nxt = s_r;
    s_nxt.rdata_r = rd_word;
    if (wr_neg) begin
      s_nxt.neg_action_r = req.wdata;
    end
    if (wr_soft) begin
      s_nxt.soft_switch_r = req.wdata;
    end
    if (wr_brk) begin
      s_nxt.break_r = req.wdata;
    end
    if (wr_ext) begin
      s_nxt.ext_result_r = req.wdata;
    end
    if (cnt_clear) begin
      s_nxt.retx_cnt_r = 4'h0;
    end else if (cnt_step) begin
      s_nxt.retx_cnt_r = s_r.retx_cnt_r + 4'h1;
    end
    if (call_start) begin
      s_nxt.recorded_r = 1'b0;
    end
    if (cause_take) begin
      s_nxt.fail_reason_r = cause;
      s_nxt.recorded_r = 1'b1;
    end else if (silent_take) begin
      s_nxt.fail_reason_r = `FAIL_NORMAL;
      s_nxt.recorded_r = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_r.neg_action_r <= `RST_NEG_ACTION;
      s_r.soft_switch_r <= `RST_SOFT_SWITCH;
      s_r.break_r <= `RST_BREAK;
      s_r.fail_reason_r <= `RST_FAIL_REASON;
      s_r.ext_result_r <= `RST_EXT_RESULT;
      s_r.rdata_r <= 8'h00;
      s_r.retx_cnt_r <= 4'h0;
      s_r.recorded_r <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rdata = s_r.rdata_r;
  assign fail_valid = s_r.recorded_r;

  // Negotiation decode
  always_comb begin
    case (s_r.neg_action_r)
      `NEG_ENABLE: begin
        neg_mode = neg_detect;
      end
      `NEG_LAPM: begin
        neg_mode = neg_lapm;
      end
      `NEG_FALLBACK: begin
        neg_mode = neg_fallback;
      end
      default: begin
        neg_mode = neg_fallback;
      end
    endcase
  end

  // Break decode
  always_comb begin
    case (s_r.break_r)
      `BRK_EXPEDITED: begin
        brk_mode = brk_expedited;
      end
      `BRK_DESTRUCTIVE: begin
        brk_mode = brk_destructive;
      end
      `BRK_IN_SEQUENCE: begin
        brk_mode = brk_in_sequence;
      end
      default: begin
        brk_mode = brk_in_sequence;
      end
    endcase
  end

  assign break_immediate = (brk_mode != brk_in_sequence);
  assign break_discard = (brk_mode == brk_destructive);

  assign command_set_select = s_r.soft_switch_r[`SW_CMD_SET];
  assign remote_config_permit = s_r.soft_switch_r[`SW_REMOTE_CFG];
  assign callback_security_enable = s_r.soft_switch_r[`SW_CALLBACK];
  assign answer_select = s_r.soft_switch_r[`SW_ANSWER];

  always_comb begin
    result_force.line_speed = s_r.ext_result_r[`XR_LINE_SPEED];
    result_force.ec_tag = s_r.ext_result_r[`XR_EC_TAG];
    result_force.carrier = s_r.ext_result_r[`XR_CARRIER];
    result_force.protocol = s_r.ext_result_r[`XR_PROTOCOL];
    result_force.compression = s_r.ext_result_r[`XR_COMPRESSION];
  end
endmodule // modem_option_register_decode

// >>> sim/modem_opt_asserts.sv
// Checker of the modem option register block
`timescale 1ns/100ps
module modem_opt_asserts (
  // Clock, reset, register port
  input wire logic clk,
  input wire logic rst,
  input wire modem_opt_pkg::reg_req_t req,
  input wire logic [7:0] rdata,
  // Events
  input wire modem_opt_pkg::fail_evt_t fail_evt,
  input wire logic call_start,
  // Decoded outputs
  input wire modem_opt_pkg::neg_mode_t neg_mode,
  input wire modem_opt_pkg::brk_mode_t brk_mode,
  input wire logic break_immediate,
  input wire logic break_discard,
  input wire logic command_set_select,
  input wire logic remote_config_permit,
  input wire logic callback_security_enable,
  input wire logic answer_select,
  input wire modem_opt_pkg::result_en_t result_force,
  input wire logic fail_valid
);
  import modem_opt_pkg::*;
  logic [7:0] w_q;
  wire wr_at0 = req.wr && req.addr == 3'h0;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  always_ff @(posedge clk) w_q <= req.wdata;
  a_neg_decode: assert property (wr_at0 |=> neg_mode == (w_q == 8'h00 ? neg_lapm :
    w_q == 8'h07 ? neg_detect : neg_fallback)) else $error("negotiation mode wrong");
  a_brk_decode: assert property (req.wr && req.addr == 3'h2 |=> brk_mode == (w_q == 8'h03 ?
    brk_expedited : w_q == 8'h07 ? brk_destructive : brk_in_sequence)) else $error("break mode wrong");
  a_brk_flags: assert property (break_immediate == (brk_mode != brk_in_sequence) &&
    break_discard == (brk_mode == brk_destructive)) else $error("break flags wrong");
  a_soft_bits: assert property (req.wr && req.addr == 3'h1 |=> {answer_select,
    callback_security_enable, remote_config_permit, command_set_select} == w_q[3:0])
    else $error("soft switch outputs wrong");
  a_ext_bits: assert property (req.wr && req.addr == 3'h4 |=> result_force ==
    {w_q[0], w_q[1], w_q[2], w_q[3], w_q[5]}) else $error("result enables wrong");
  a_neg_readback: assert property (wr_at0 ##1 req.rd && req.addr == 3'h0 |=>
    rdata == $past(req.wdata, 2)) else $error("stored value lost");
  a_cause_held: assert property (fail_valid && !call_start |=> fail_valid)
    else $error("cause capture dropped");
  a_carrier_cause: assert property (!fail_valid && fail_evt.carrier_loss && !call_start
    |=> fail_valid) else $error("carrier loss not recorded");
  c_fallback: cover property (neg_mode == neg_fallback);
  c_discard: cover property (break_discard);
  c_cause: cover property ($rose(fail_valid));
endmodule // modem_opt_asserts
bind modem_option_register_decode modem_opt_asserts modem_opt_asserts_i (.clk(clk), .rst(rst),
  .req(req), .rdata(rdata), .fail_evt(fail_evt), .call_start(call_start), .neg_mode(neg_mode),
  .brk_mode(brk_mode), .break_immediate(break_immediate), .break_discard(break_discard),
  .command_set_select(command_set_select), .remote_config_permit(remote_config_permit),
  .callback_security_enable(callback_security_enable), .answer_select(answer_select),
  .result_force(result_force), .fail_valid(fail_valid));

// >>> sim/remote_modem.sv
// Remote modem model raising one link event per request
`timescale 1ns/100ps
module remote_modem (
  // Clock and request
  input wire logic clk,
  input wire logic go,
  input wire logic [2:0] kind,
  // Events
  output modem_opt_pkg::fail_evt_t fail_evt,
  output logic no_carrier
);
  import modem_opt_pkg::*;
  always @(posedge clk) begin
    fail_evt <= go && kind != 3'h7 ? fail_evt_t'(7'h40 >> kind) : '0;
    no_carrier <= go && kind == 3'h7;
  end
endmodule // remote_modem

// >>> sim/modem_option_register_decode_tb.sv
// Testbench of the modem option register block
`timescale 1ns/100ps
`include "modem_opt_params.svh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_fail++; \
  $display("mismatch at %0t: got %h exp %h", $time, g, e); end end
module modem_option_register_decode_tb;
  import modem_opt_pkg::*;
  logic clk = 0, rst = 1, retx_event = 0, ack_event = 0, call_start = 0, go = 0;
  logic [2:0] kind = 0;
  logic [7:0] d, rdata;
  int n_fail = 0, check_count = 0;
  reg_req_t req = '0;
  fail_evt_t fail_evt;
  neg_mode_t neg_mode;
  brk_mode_t brk_mode;
  result_en_t result_force;
  logic no_carrier, break_immediate, break_discard, command_set_select, remote_config_permit;
  logic callback_security_enable, answer_select, fail_valid;
  always #25 clk = ~clk;
  modem_option_register_decode modem_option_register_decode_i (.clk(clk), .rst(rst), .req(req),
    .rdata(rdata), .fail_evt(fail_evt), .retx_event(retx_event), .ack_event(ack_event),
    .no_carrier(no_carrier), .call_start(call_start), .neg_mode(neg_mode), .brk_mode(brk_mode),
    .break_immediate(break_immediate), .break_discard(break_discard),
    .command_set_select(command_set_select), .remote_config_permit(remote_config_permit),
    .callback_security_enable(callback_security_enable), .answer_select(answer_select),
    .result_force(result_force), .fail_valid(fail_valid));
  remote_modem remote_modem_i (.clk(clk), .go(go), .kind(kind), .fail_evt(fail_evt),
    .no_carrier(no_carrier));
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk) req <= '{a, v, 1'b1, 1'b0};
  endtask
  task automatic rd(input logic [2:0] a);
    @(posedge clk) req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk) req <= '0;
    #1 d = rdata;
  endtask
  task automatic ev(input logic [2:0] k);
    @(posedge clk) begin
      go <= 1;
      kind <= k;
    end
    @(posedge clk) go <= 0;
  endtask
  task automatic rt(input int n);
    repeat (n) begin
      @(posedge clk) retx_event <= 1;
      @(posedge clk) retx_event <= 0;
    end
  endtask
  task automatic new_call;
    @(posedge clk) call_start <= 1;
    @(posedge clk) call_start <= 0;
    #1;
  endtask
  task automatic t_reset;
    logic [7:0] e[6] = '{8'h07, 8'h00, 8'h80, 8'h00, 8'h00, 8'h00};
    `CHK(neg_mode, neg_detect)
    for (int i = 0; i < 6; i++) begin
      rd(i[2:0]);
      `CHK(d, e[i])
    end
  endtask
  task automatic t_decode;
    logic [7:0] v[4] = '{8'h00, 8'h07, 8'h80, 8'h05};
    logic [7:0] b[4] = '{8'h03, 8'h07, 8'h80, 8'h00};
    neg_mode_t m[4] = '{neg_lapm, neg_detect, neg_fallback, neg_fallback};
    logic [1:0] f[4] = '{2'h2, 2'h3, 2'h0, 2'h0};
    for (int i = 0; i < 4; i++) begin
      wr(`OFS_NEG_ACTION, v[i]);
      rd(`OFS_NEG_ACTION);
      `CHK(d, v[i])
      `CHK(neg_mode, m[i])
      wr(`OFS_BREAK, b[i]);
      rd(`OFS_BREAK);
      `CHK(d, b[i])
      `CHK({break_immediate, break_discard}, f[i])
    end
  endtask
  task automatic t_bits;
    logic [7:0] v[2] = '{8'hf5, 8'h0a};
    logic [7:0] x[2] = '{8'hd6, 8'h29};
    logic [4:0] xe[2] = '{5'h0c, 5'h13};
    for (int i = 0; i < 2; i++) begin
      wr(`OFS_SOFT_SWITCH, v[i]);
      rd(`OFS_SOFT_SWITCH);
      `CHK(d, v[i])
      `CHK({answer_select, callback_security_enable, remote_config_permit, command_set_select}, v[i][3:0])
      wr(`OFS_EXT_RESULT, x[i]);
      rd(`OFS_EXT_RESULT);
      `CHK(d, x[i])
      `CHK(result_force, xe[i])
    end
  endtask
  task automatic t_cause;
    logic [7:0] c[8] = '{8'h04, 8'h05, 8'h09, 8'h0c, 8'h0d, 8'h0e, 8'h00, 8'h00};
    for (int k = 0; k < 8; k++) begin
      new_call;
      `CHK(fail_valid, 1'b0)
      ev(k[2:0]);
      ev(k == 0 ? 3'h1 : 3'h0);
      rd(`OFS_FAIL_REASON);
      `CHK(d, c[k])
      `CHK(fail_valid, 1'b1)
    end
  endtask
  task automatic t_retx;
    new_call;
    rt(9);
    @(posedge clk) ack_event <= 1;
    @(posedge clk) ack_event <= 0;
    rt(9);
    #1 `CHK(fail_valid, 1'b0)
    rt(1);
    rd(`OFS_FAIL_REASON);
    `CHK(d, 8'h0d)
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst <= 0;
    t_reset;
    t_decode;
    t_bits;
    t_cause;
    t_retx;
    test_done;
  end
endmodule // modem_option_register_decode_tb
